//--- dv/qcic_encoder_model.sv
`timescale 1ns/1ns
// two-phase encoder with index; one quarter step per command
module qcic_encoder_model (
  // clock
  input  wire logic       clk,
  // step command: 1 forward, 2 backward; index request
  input  wire logic [1:0] cmd,
  input  wire logic       idxReq,
  // encoder outputs
  output logic            phaseA,
  output logic            phaseB,
  output logic            index
);
  logic [1:0] pos_r = 2'h0;  // binary position, decoded to gray so only one phase moves per step
  // quarter-step position keeps the two trains a quarter apart
  always_ff @(posedge clk) begin
    if (cmd == 2'h1) pos_r <= pos_r + 2'h1;
    if (cmd == 2'h2) pos_r <= pos_r - 2'h1;
    index <= idxReq;
  end
  assign phaseA = pos_r[0] ^ pos_r[1];
  assign phaseB = pos_r[1];
endmodule

//--- dv/tb_qcic_counter_top.sv
`timescale 1ns/1ns
module tb_qcic_counter_top;
  logic clk = 1'b0, rst_b = 1'b0, awv = 1'b0, wv = 1'b0, bRdy = 1'b0, arv = 1'b0, rRdy = 1'b0;
  logic [7:0]  awA = 8'h00, arA = 8'h00;
  logic [31:0] wD = 32'h0, rD;
  logic [1:0]  bR, rR, pOut, pOe, cmd = 2'h0;
  logic awR, wR, bV, arR, rV, irq, encA, encB, encZ, idxReq = 1'b0;
  int errorCnt = 0, totalChecks = 0, cyc = 0;
  // alt pair swapped so a wrong pair choice shows as a reversed count
  qcic_counter_top i_dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awA), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wR), .s_axi_bresp(bR), .s_axi_bvalid(bV),
    .s_axi_bready(bRdy), .s_axi_araddr(arA), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rR), .s_axi_rvalid(rV),
    .s_axi_rready(rRdy), .phaseAClockPin(encA), .phaseBClockPin(encB),
    .phaseAInvertingPin(~encA), .phaseBInvertingPin(~encB), .altPhaseAClockPin(encB),
    .altPhaseBClockPin(encA), .altPhaseAInvertingPin(~encB), .altPhaseBInvertingPin(~encA),
    .indexCapturePin({1'b0, encZ}), .secondCaptureComparePinOut(pOut),
    .secondCaptureComparePinOe(pOe), .irq(irq));
  qcic_encoder_model i_enc (.clk(clk), .cmd(cmd), .idxReq(idxReq), .phaseA(encA),
    .phaseB(encB), .index(encZ));
  initial forever #25 clk = ~clk;
  // watchdog: whole run is well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      conclude();
    end
  end
  task automatic conclude();
    if (errorCnt == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    totalChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit done = 0;
    awA <= a; wD <= d; awv <= 1'b1; wv <= 1'b1; bRdy <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awR) awv <= 1'b0;
      if (wR) wv <= 1'b0;
      if (bV) begin done = 1; bRdy <= 1'b0; chk(bR, r); end
    end
    @(posedge clk);  // one idle edge so ready is never re-raised in the same step
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    bit done = 0;
    arA <= a; arv <= 1'b1; rRdy <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arR) arv <= 1'b0;
      if (rV) begin done = 1; rRdy <= 1'b0; chk(rD, e); chk(rR, r); end
    end
    @(posedge clk);  // one idle edge so ready is never re-raised in the same step
  endtask
  // spaced steps so every edge is seen alone
  task automatic step(input logic [1:0] c, input int n);
    repeat (n) begin
      cmd <= c; @(posedge clk); cmd <= 2'h0; repeat (3) @(posedge clk);
    end
  endtask
  task automatic tReset();
    rd(8'h00, 32'h3, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    chk(irq, 0);
    chk(pOe, 0);
  endtask
  // reset in mid-run with phase a high and b low: release must not count a false edge
  task automatic tReRst();
    step(2'h1, 1);
    rst_b <= 1'b0; repeat (3) @(posedge clk); rst_b <= 1'b1;
    rd(8'h00, 32'h3, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h40, 32'h0, 2'h0);
  endtask
  task automatic tCount();
    step(2'h1, 3);
    rd(8'h04, 32'h3, 2'h0);
    step(2'h2, 4);
    rd(8'h04, 32'hffff, 2'h0);
    rd(8'h24, 32'hffff, 2'h0);
    rd(8'h40, 32'h44, 2'h0);
    wr(8'h44, 32'h04, 2'h0);
    chk(irq, 1);
    wr(8'h40, 32'h44, 2'h0);
    chk(irq, 0);
    step(2'h1, 1);
    rd(8'h40, 32'h22, 2'h0);
    chk(irq, 0);
    wr(8'h40, 32'hff, 2'h0);
  endtask
  task automatic tIndex();
    step(2'h1, 5);
    idxReq <= 1'b1; repeat (2) @(posedge clk); idxReq <= 1'b0; repeat (3) @(posedge clk);
    rd(8'h08, 32'h5, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h24, 32'h5, 2'h0);
    rd(8'h40, 32'h01, 2'h0);
    wr(8'h40, 32'hff, 2'h0);
  endtask
  task automatic tPins();
    wr(8'h00, 32'h15, 2'h0);
    wr(8'h20, 32'h19, 2'h0);
    wr(8'h04, 32'h0, 2'h0);
    wr(8'h24, 32'h0, 2'h0);
    step(2'h1, 2);
    rd(8'h04, 32'h2, 2'h0);
    rd(8'h24, 32'hfffe, 2'h0);
    wr(8'h40, 32'hff, 2'h0);
  endtask
  task automatic tCmp();
    wr(8'h0c, 32'h3, 2'h0);
    wr(8'h00, 32'h61, 2'h0);
    chk(pOe, 2'h1);
    chk(pOut, 2'h0);
    step(2'h1, 1);
    chk(pOut, 2'h1);
    rd(8'h40, 32'h08, 2'h0);
    wr(8'h00, 32'h01, 2'h0);
    chk(pOe, 2'h0);
    wr(8'h50, 32'h1, 2'h3);
    rd(8'h50, 32'h0, 2'h3);
    wr(8'h08, 32'h77, 2'h0);
    rd(8'h08, 32'h5, 2'h0);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    tReset();
    tCount();
    tIndex();
    tPins();
    tCmp();
    tReRst();
    conclude();
  end
endmodule

//--- hw/qcic_chan_if.sv
`timescale 1ns/1ns
interface qcic_chan_if;
  logic                         phaseA;    // selected a phase
  logic                         phaseB;    // selected b phase
  logic                         index;     // index capture input
  logic                         enable;    // counting on
  logic                         clrOnCap;  // capture clears counter
  logic                         grbCmp;    // register b in compare use
  logic                         cmpLevel;  // level on match
  logic                         cntWr;     // software counter write
  logic                         grbWr;     // software register b write
  logic [qcic_pkg::CNT_W-1:0]   wdata;     // merged write data
  logic [qcic_pkg::CNT_W-1:0]   cnt;       // counter value
  logic [qcic_pkg::CNT_W-1:0]   gra;       // capture register a
  logic [qcic_pkg::CNT_W-1:0]   grb;       // compare register b
  logic                         capEv;     // capture pulse
  logic                         ovfEv;     // overflow pulse
  logic                         udfEv;     // underflow pulse
  logic                         cmpEv;     // compare match pulse
  logic                         pinOut;    // compare pin level
  modport top (output phaseA, phaseB, index, enable, clrOnCap, grbCmp, cmpLevel,
               output cntWr, grbWr, wdata,
               input  cnt, gra, grb, capEv, ovfEv, udfEv, cmpEv, pinOut);
  modport chan (input  phaseA, phaseB, index, enable, clrOnCap, grbCmp, cmpLevel,
                input  cntWr, grbWr, wdata,
                output cnt, gra, grb, capEv, ovfEv, udfEv, cmpEv, pinOut);
endinterface

//--- hw/qcic_counter_top.sv
`timescale 1ns/1ns
// Function
// RQ1: each channel is a 16-bit phase counter
// RQ2: encoder supplies two phase-shifted pulse trains
// RQ3: mode one up-count edge and level pairs
// RQ4: mode one down-count edge and level pairs
// RQ5: direction set only by phase relation
// RQ6: index rising edge captures counter into register
// RQ7: capture clears counter when selected as source
// RQ8: both channels count fully independently
// RQ9: channel one limited to first pin pair
// RQ10: inverting pin feeds phase with opposite sense
// RQ11: compare match drives pin to chosen level
// RQ12: unused second pin released for other use
// RQ13: wrap with overflow and underflow flags, interruptible
// RQ14: capture sets flag, may raise interrupt
module qcic_counter_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // first external clock pin pair, true and inverting
  input  wire logic        phaseAClockPin,
  input  wire logic        phaseBClockPin,
  input  wire logic        phaseAInvertingPin,
  input  wire logic        phaseBInvertingPin,
  // second external clock pin pair, true and inverting
  input  wire logic        altPhaseAClockPin,
  input  wire logic        altPhaseBClockPin,
  input  wire logic        altPhaseAInvertingPin,
  input  wire logic        altPhaseBInvertingPin,
  // index capture input, one per channel
  input  wire logic [1:0]  indexCapturePin,
  // second capture/compare pin, one per channel
  output logic [1:0]       secondCaptureComparePinOut,
  output logic [1:0]       secondCaptureComparePinOe,
  // interrupt
  output logic             irq
);
  localparam int NCH = qcic_pkg::NCH;
  localparam int CW  = qcic_pkg::CNT_W;

  // protection bits carry nothing for this block
  logic unusedProt;
  assign unusedProt = ^{s_axi_awprot, s_axi_arprot};

  // write channel holding state
  logic                            awHeld_r;   // write address captured
  logic                            wHeld_r;    // write data captured
  logic [7:0]                      awAddr_r;
  logic [31:0]                     wData_r;
  logic [3:0]                      wStrb_r;
  logic                            bValid_r;
  logic [1:0]                      bResp_r;
  logic                            doWrite;    // one-cycle register update
  // read channel state
  logic                            rValid_r;
  logic [31:0]                     rData_r;
  logic [1:0]                      rResp_r;
  logic [31:0]                     rdMux;
  // software registers
  logic [qcic_pkg::CTRL_W-1:0]     ctrl_r [NCH];
  logic [qcic_pkg::STAT_W-1:0]     stat_r;
  logic [qcic_pkg::STAT_W-1:0]     mask_r;
  logic [qcic_pkg::STAT_W-1:0]     statSet;    // hardware event pulses
  logic [qcic_pkg::STAT_W-1:0]     statClr;    // write-one-to-clear
  // channel results gathered for the read path
  logic [CW-1:0]                   cntV [NCH];
  logic [CW-1:0]                   graV [NCH];
  logic [CW-1:0]                   grbV [NCH];

  // word compare, the low two address bits are ignored
  function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
    regHit = (a[7:2] == off[7:2]);
  endfunction

  // one decode shared by write response and read response
  function automatic logic isMapped(input logic [7:0] a);
    logic hit;
    hit = regHit(a, qcic_pkg::OFF_STAT) | regHit(a, qcic_pkg::OFF_MASK);
    for (int c = 0; c < NCH; c++) begin
      hit = hit | regHit(a, qcic_pkg::OFF_CTRL  + 8'(c * 32))
                | regHit(a, qcic_pkg::OFF_COUNT + 8'(c * 32))
                | regHit(a, qcic_pkg::OFF_CAPA  + 8'(c * 32))
                | regHit(a, qcic_pkg::OFF_CMPB  + 8'(c * 32));
    end
    isMapped = hit;
  endfunction

  // byte lanes 0 and 1 are the only live ones, upper lanes drop
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // address and data may arrive in either order, each held until both are in
  assign s_axi_awready = !awHeld_r;
  assign s_axi_wready  = !wHeld_r;
  assign doWrite       = awHeld_r && wHeld_r && !bValid_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;

  // write address capture
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
    end else if (s_axi_awvalid && !awHeld_r) begin
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_r <= 1'b0;
    end
  end

  // write data capture
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wHeld_r <= 1'b0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end else if (s_axi_wvalid && !wHeld_r) begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_r <= 1'b0;
    end
  end

  // write response, unmapped words answer decode error
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bValid_r <= 1'b0;
      bResp_r  <= qcic_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bValid_r <= 1'b1;
      bResp_r  <= isMapped(awAddr_r) ? qcic_pkg::RESP_OKAY : qcic_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      bValid_r <= 1'b0;
    end
  end

  // shared event registers, clear wins never: a new event beats the clear
  assign statClr = (doWrite && regHit(awAddr_r, qcic_pkg::OFF_STAT) && wStrb_r[0])
                   ? wData_r[qcic_pkg::STAT_W-1:0] : qcic_pkg::STAT_RST;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stat_r <= qcic_pkg::STAT_RST;
    end else begin
      stat_r <= (stat_r & ~statClr) | statSet;              // [RQ13] [RQ14]
    end
  end

  // interrupt mask
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mask_r <= qcic_pkg::MASK_RST;
    end else if (doWrite && regHit(awAddr_r, qcic_pkg::OFF_MASK) && wStrb_r[0]) begin
      mask_r <= wData_r[qcic_pkg::STAT_W-1:0];
    end
  end

  // level interrupt from stored flags only
  assign irq = |(stat_r & mask_r);                          // [RQ13] [RQ14]

  // two independent channels, each with its own settings
  for (genvar g = 0; g < NCH; g++) begin : gCh                // [RQ8]
    localparam logic [7:0] BASE = (g == 0) ? 8'h00 : qcic_pkg::CH_STRIDE;
    qcic_chan_if chIf ();
    logic useAlt;     // second pair selected and allowed
    logic aSrc;       // a phase after inversion choice
    logic bSrc;

    // control register of this channel
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        ctrl_r[g] <= qcic_pkg::CTRL_RST;
      end else if (doWrite && regHit(awAddr_r, qcic_pkg::OFF_CTRL + BASE)
                   && wStrb_r[0]) begin
        ctrl_r[g] <= wData_r[qcic_pkg::CTRL_W-1:0];
      end
    end

    // channel one never reaches the second pair, whatever software writes
    assign useAlt = (g != 0) && ctrl_r[g][qcic_pkg::CB_ALT];  // [RQ9]
    // the inverting pin is folded back so the counter sees one sense
    always_comb begin
      if (ctrl_r[g][qcic_pkg::CB_AINV]) begin
        aSrc = useAlt ? ~altPhaseAInvertingPin : ~phaseAInvertingPin;   // [RQ10]
      end else begin
        aSrc = useAlt ? altPhaseAClockPin : phaseAClockPin;
      end
      if (ctrl_r[g][qcic_pkg::CB_BINV]) begin
        bSrc = useAlt ? ~altPhaseBInvertingPin : ~phaseBInvertingPin;   // [RQ10]
      end else begin
        bSrc = useAlt ? altPhaseBClockPin : phaseBClockPin;
      end
    end

    // inputs to the channel
    assign chIf.phaseA   = aSrc;
    assign chIf.phaseB   = bSrc;
    assign chIf.index    = indexCapturePin[g];
    assign chIf.enable   = ctrl_r[g][qcic_pkg::CB_EN];
    assign chIf.clrOnCap = ctrl_r[g][qcic_pkg::CB_CLR];
    assign chIf.grbCmp   = ctrl_r[g][qcic_pkg::CB_CMP];
    assign chIf.cmpLevel = ctrl_r[g][qcic_pkg::CB_LVL];
    assign chIf.cntWr    = doWrite && regHit(awAddr_r, qcic_pkg::OFF_COUNT + BASE);
    assign chIf.grbWr    = doWrite && regHit(awAddr_r, qcic_pkg::OFF_CMPB + BASE);
    // partial writes keep the bytes not strobed
    assign chIf.wdata    = merge16(regHit(awAddr_r, qcic_pkg::OFF_COUNT + BASE)
                                   ? chIf.cnt : chIf.grb, wData_r, wStrb_r);

    qcic_phase_chan uChan (
      .clk   (clk),
      .rst_b (rst_b),
      .ch    (chIf.chan)
    );

    // results for read path and event register
    assign cntV[g] = chIf.cnt;
    assign graV[g] = chIf.gra;
    assign grbV[g] = chIf.grb;
    assign statSet[g*qcic_pkg::SB_W +: qcic_pkg::SB_W] =
      {chIf.cmpEv, chIf.udfEv, chIf.ovfEv, chIf.capEv};
    // pin only driven while register b is in compare use
    assign secondCaptureComparePinOut[g] = chIf.pinOut;       // [RQ11]
    assign secondCaptureComparePinOe[g]  = ctrl_r[g][qcic_pkg::CB_CMP];  // [RQ12]

    pin_release_a: assert property (@(posedge clk) disable iff (!rst_b) // [RQ12]
      !ctrl_r[g][qcic_pkg::CB_CMP] |-> !secondCaptureComparePinOe[g])
      else $error("second pin driven while not in compare use");
    inv_sense_a: assert property (@(posedge clk) disable iff (!rst_b) // [RQ10]
      (ctrl_r[g][qcic_pkg::CB_AINV] && !useAlt) |-> chIf.phaseA != phaseAInvertingPin)
      else $error("inverting pin not folded back");
  end

  // read data selection, unmapped words read as zero
  always_comb begin
    rdMux = 32'h0000_0000;
    if (regHit(s_axi_araddr, qcic_pkg::OFF_STAT)) begin
      rdMux[qcic_pkg::STAT_W-1:0] = stat_r;
    end else if (regHit(s_axi_araddr, qcic_pkg::OFF_MASK)) begin
      rdMux[qcic_pkg::STAT_W-1:0] = mask_r;
    end
    for (int c = 0; c < NCH; c++) begin
      if (regHit(s_axi_araddr, qcic_pkg::OFF_CTRL + 8'(c * 32))) begin
        rdMux[qcic_pkg::CTRL_W-1:0] = ctrl_r[c];
      end else if (regHit(s_axi_araddr, qcic_pkg::OFF_COUNT + 8'(c * 32))) begin
        rdMux[CW-1:0] = cntV[c];
      end else if (regHit(s_axi_araddr, qcic_pkg::OFF_CAPA + 8'(c * 32))) begin
        rdMux[CW-1:0] = graV[c];
      end else if (regHit(s_axi_araddr, qcic_pkg::OFF_CMPB + 8'(c * 32))) begin
        rdMux[CW-1:0] = grbV[c];
      end
    end
  end

  // one read at a time, address refused while data waits
  assign s_axi_arready = !rValid_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;

  // read response register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rValid_r <= 1'b0;
      rData_r  <= 32'h0000_0000;
      rResp_r  <= qcic_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rValid_r) begin
      rValid_r <= 1'b1;
      rData_r  <= rdMux;
      rResp_r  <= isMapped(s_axi_araddr) ? qcic_pkg::RESP_OKAY : qcic_pkg::RESP_DECERR;
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  // the encoder is trusted to send two shifted trains; nothing checks it
  // beyond the ambiguous double-edge case, which simply does not count  [RQ2]

  irq_mask_a: assert property (@(posedge clk) disable iff (!rst_b) // [RQ13]
    (mask_r == 8'h00) |-> !irq)
    else $error("interrupt raised with all sources masked");
  flag_set_a: assert property (@(posedge clk) disable iff (!rst_b) // [RQ14]
    (statSet[qcic_pkg::SB_CAP]) |=> stat_r[qcic_pkg::SB_CAP])
    else $error("capture flag not set");
endmodule

//--- hw/qcic_phase_chan.sv
`timescale 1ns/1ns
module qcic_phase_chan (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control and results
  qcic_chan_if.chan ch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic                       aPrev_r;   // a phase one cycle ago
  logic                       bPrev_r;   // b phase one cycle ago
  logic                       idxPrev_r; // index one cycle ago
  logic                       matchPrev_r;
  logic [qcic_pkg::CNT_W-1:0] cnt_r;
  logic [qcic_pkg::CNT_W-1:0] gra_r;
  logic [qcic_pkg::CNT_W-1:0] grb_r;
  logic                       pin_r;
  logic aRise, aFall, bRise, bFall, upHit, dnHit;
  logic idxRise, capClr, stepUp, stepDn, match;

  // edge detection on the selected phases
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      // track the live levels in reset so release never shows a false edge
      aPrev_r     <= ch.phaseA;
      bPrev_r     <= ch.phaseB;
      idxPrev_r   <= ch.index;
      matchPrev_r <= 1'b0;
    end else begin
      aPrev_r     <= ch.phaseA;
      bPrev_r     <= ch.phaseB;
      idxPrev_r   <= ch.index;
      matchPrev_r <= match;
    end
  end

  assign aRise = ch.phaseA & ~aPrev_r;
  assign aFall = ~ch.phaseA & aPrev_r;
  assign bRise = ch.phaseB & ~bPrev_r;
  assign bFall = ~ch.phaseB & bPrev_r;
  // direction comes only from how the two waveforms relate
  assign upHit = (bRise & ch.phaseA) | (bFall & ~ch.phaseA) |
                 (aRise & ~ch.phaseB) | (aFall & ch.phaseB);    // [RQ3] [RQ5]
  assign dnHit = (bFall & ch.phaseA) | (bRise & ~ch.phaseA) |
                 (aRise & ch.phaseB) | (aFall & ~ch.phaseB);    // [RQ4] [RQ5]
  // both edges at once is ambiguous, so it counts nothing
  assign stepUp  = ch.enable & upHit & ~dnHit & ~ch.cntWr & ~capClr;
  assign stepDn  = ch.enable & dnHit & ~upHit & ~ch.cntWr & ~capClr;
  assign idxRise = ch.index & ~idxPrev_r;
  assign capClr  = idxRise & ch.clrOnCap;                    // [RQ7]
  assign match   = ch.grbCmp & (cnt_r == grb_r);

  // 16-bit counter, software write beats index clear beats stepping
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_r <= qcic_pkg::CNT_RST;
    end else if (ch.cntWr) begin
      cnt_r <= ch.wdata;
    end else if (capClr) begin
      cnt_r <= qcic_pkg::CNT_RST;                            // [RQ7]
    end else if (stepUp) begin
      cnt_r <= cnt_r + 16'h0001;                             // [RQ1] [RQ13]
    end else if (stepDn) begin
      cnt_r <= cnt_r - 16'h0001;                             // [RQ1] [RQ13]
    end
  end

  // capture on index rising edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gra_r <= qcic_pkg::GR_RST;
    end else if (idxRise) begin
      gra_r <= cnt_r;                                        // [RQ6]
    end
  end

  // compare register and its output pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      grb_r <= qcic_pkg::GR_RST;
      pin_r <= 1'b0;
    end else begin
      if (ch.grbWr) begin
        grb_r <= ch.wdata;
      end
      if (match) begin
        pin_r <= ch.cmpLevel;                                // [RQ11]
      end
    end
  end

  assign ch.cnt    = cnt_r;
  assign ch.gra    = gra_r;
  assign ch.grb    = grb_r;
  assign ch.pinOut = pin_r;
  assign ch.capEv  = idxRise;                                // [RQ14]
  assign ch.ovfEv  = stepUp & (cnt_r == 16'hffff);           // [RQ13]
  assign ch.udfEv  = stepDn & (cnt_r == 16'h0000);           // [RQ13]
  assign ch.cmpEv  = match & ~matchPrev_r;

  up_count_a: assert property ((ch.enable && !ch.cntWr && !capClr && $rose(ch.phaseB) // [RQ3]
    && ch.phaseA && $stable(ch.phaseA)) |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("count did not rise on b rise with a high");
  down_count_a: assert property ((ch.enable && !ch.cntWr && !capClr && $fell(ch.phaseB) // [RQ4]
    && ch.phaseA && $stable(ch.phaseA)) |=> cnt_r == $past(cnt_r) - 16'h0001)
    else $error("count did not fall on b fall with a high");
  count_hold_a: assert property (($stable(ch.phaseA) && $stable(ch.phaseB) // [RQ5]
    && !ch.cntWr && !idxRise) |=> $stable(cnt_r))
    else $error("count moved without a phase edge");
  index_capture_a: assert property ($rose(ch.index) |=> gra_r == $past(cnt_r)) // [RQ6]
    else $error("index edge did not capture count");
  index_clear_a: assert property (($rose(ch.index) && ch.clrOnCap && !ch.cntWr) // [RQ7]
    |=> cnt_r == 16'h0000)
    else $error("capture did not clear count");
  wrap_flag_a: assert property (ch.ovfEv |=> cnt_r == 16'h0000) // [RQ13]
    else $error("overflow flagged without wrap");
  cap_flag_a: assert property ($rose(ch.index) |-> ch.capEv) // [RQ14]
    else $error("capture event missing");
  cmp_pin_a: assert property ((ch.grbCmp && cnt_r == grb_r) // [RQ11]
    |=> pin_r == $past(ch.cmpLevel))
    else $error("compare pin not set on match");
endmodule

//--- hw/qcic_pkg.sv
package qcic_pkg;
  // channel count and widths
  localparam int NCH   = 2;
  localparam int CNT_W = 16;
  localparam int SB_W  = 4;
  localparam int STAT_W = NCH * SB_W;
  localparam int CTRL_W = 7;
  // per-channel register byte offsets, channel two sits one stride higher
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_CAPA  = 8'h08;
  localparam logic [7:0] OFF_CMPB  = 8'h0c;
  // shared event registers
  localparam logic [7:0] OFF_STAT  = 8'h40;
  localparam logic [7:0] OFF_MASK  = 8'h44;
  // control field positions
  localparam int CB_EN   = 0;  // counting enabled
  localparam int CB_CLR  = 1;  // capture a clears counter
  localparam int CB_AINV = 2;  // a phase from inverting pin
  localparam int CB_BINV = 3;  // b phase from inverting pin
  localparam int CB_ALT  = 4;  // second pin pair, channel two only
  localparam int CB_CMP  = 5;  // register b is compare, pin driven
  localparam int CB_LVL  = 6;  // level driven on compare match
  // status field positions inside a channel's nibble
  localparam int SB_CAP = 0;
  localparam int SB_OVF = 1;
  localparam int SB_UDF = 2;
  localparam int SB_CMP = 3;
  // values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h03;
  localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
  localparam logic [CNT_W-1:0]  GR_RST   = 16'h0000;
  localparam logic [STAT_W-1:0] STAT_RST = 8'h00;
  localparam logic [STAT_W-1:0] MASK_RST = 8'h00;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage
